// >>> rtl/sfpi_pkg.sv
// serial flash pin front end: constants, types, behaviour list
// assumes one core clock; pins arrive unsynchronised
//
// Behaviour
// RULE1: select high: deselected, outputs high impedance
// RULE2: deselected idles unless internal cycle busy
// RULE3: select low makes device active
// RULE4: select falling edge needed before any instruction
// RULE5: single lane samples serial_in on rise
// RULE6: single lane output changes on fall
// RULE7: multi lane: sample rise, drive fall
// RULE8: quad only with quad_enable_bit; pins become lanes
// RULE9: protect pin with lock bits blocks writes
// RULE10: quad_enable_bit disables hardware protect function
// RULE11: pause: tri-state output, ignore input, stay selected
// RULE12: pause release resumes where it stopped
// RULE13: quad_enable_bit disables pause function
// RULE14: program_boost honoured only in single lane
// RULE15: 32768 pages of 256 bytes, one page
// RULE16: erase 4K sector, 32K, 64K blocks, chip
// RULE17: link clock at most 133 MHz
// RULE18: modes 0 and 3, idle level at select
// RULE19: pause edges count only while clock low
// RULE20: select high during pause resets serial logic
// RULE21: reset defaults to SPI, not four_wire mode
// RULE22: host releases lanes before device drives
package sfpi_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] STAT_ADDR   = 8'h04;
  localparam logic [7:0] TXD_ADDR    = 8'h08;
  localparam logic [7:0] RXD_ADDR    = 8'h0c;
  localparam logic [7:0] ERASE_ADDR  = 8'h10;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  // ==========================================================
  // geometry
  localparam int PAGE_COUNT   = 32768;
  localparam int PAGE_BYTES   = 256;
  localparam int ADDR_W       = 23;
  localparam int SECTOR_BYTES = 4096;
  localparam int BLK32_BYTES  = 32768;
  localparam int BLK64_BYTES  = 65536;
  // ==========================================================
  // link timing: fastest link period and its core-clock count
  localparam int CLK_PERIOD_PS  = 8000;
  localparam int SCLK_MAX_MHZ   = 133;
  localparam int SCLK_MIN_PS    = 1000000 / SCLK_MAX_MHZ;
  localparam int SCLK_MIN_CYC   = (SCLK_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // an edge closer than this cannot be resolved by the samplers
  localparam logic [3:0] EDGE_GAP_MIN = 4'h2;
  // ==========================================================
  typedef enum logic [1:0] {
    W_SINGLE = 2'h0,
    W_DUAL   = 2'h1,
    W_QUAD   = 2'h2
  } sfpi_width_t;
  typedef enum logic [1:0] {
    ER_SECTOR = 2'h0,
    ER_BLK32  = 2'h1,
    ER_BLK64  = 2'h2,
    ER_CHIP   = 2'h3
  } sfpi_erase_t;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h1,
    ST_ACTIVE = 3'h2,
    ST_PAUSE  = 3'h4
  } sfpi_state_t;
  // software control word
  typedef struct packed {
    logic [2:0]  block_protect;   // 11..9
    logic        top_bottom_select;
    logic [1:0]  status_lock_bits;
    logic        busy;
    logic        drive_out;
    sfpi_width_t width;
    logic        four_wire_command_mode;
    logic        quad_enable_bit;
  } sfpi_ctrl_t;
endpackage

// >>> rtl/sfpi_sync.sv
// two-flop synchroniser for a group of pin levels
// assumes levels only, no pulses narrower than two clocks
`timescale 1ns/10ps
`default_nettype none
module sfpi_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sfpi_sync_t;
  sfpi_sync_t st_r, st_nxt;

  // ==========================================================
  // first stage feeds only the second
  always_comb begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;
endmodule
`default_nettype wire

// >>> rtl/sfpi_hold.sv
// pause tracker for the hold pin
// assumes synchronised inputs on the core clock
`timescale 1ns/10ps
`default_nettype none
module sfpi_hold (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic cs_n,
  input  wire logic sclk,
  input  wire logic hold_n,
  input  wire logic enable,
  output logic      paused
);
  typedef struct packed {
    logic hold_d;
    logic paused;
  } sfpi_hold_t;
  sfpi_hold_t st_r, st_nxt;

  // ==========================================================
  // edges only count with clock low
  always_comb begin
    st_nxt        = st_r;
    st_nxt.hold_d = hold_n;
    if (cs_n || !enable) begin
      st_nxt.paused = 1'b0;                       // RULE20 RULE13
    end else if (st_r.hold_d && !hold_n && !sclk) begin
      st_nxt.paused = 1'b1;                       // RULE19
    end else if (!st_r.hold_d && hold_n && !sclk) begin
      st_nxt.paused = 1'b0;                       // RULE19 RULE12
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{hold_d: 1'b1, paused: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign paused = st_r.paused;
endmodule
`default_nettype wire

// >>> rtl/sfpi_core.sv
// serial flash pin front end with wishbone control registers
// assumes link pins asynchronous to CLOCK, link below CLOCK/4
//
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module sfpi_core
  import sfpi_pkg::*;
(
  // clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  // wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // link pins
  input  wire logic        SELECT_N,
  input  wire logic        SCLK,
  input  wire logic [3:0]  DATA_LANE_I,
  output logic      [3:0]  DATA_LANE_O,
  output logic      [3:0]  DATA_LANE_OE_N,
  // side pins
  input  wire logic        PROGRAM_BOOST_REQ,
  output logic             STANDBY,
  output logic             BOOST_EN
);
  typedef struct packed {
    sfpi_state_t  state;
    logic         sclk_d;
    logic         cs_d;
    logic         armed;
    logic         idle_high;
    logic [7:0]   sh_in;
    logic [3:0]   in_cnt;
    logic [7:0]   sh_out;
    logic [3:0]   out_cnt;
    logic [7:0]   rx_byte;
    logic         rx_valid;
    logic [8:0]   page_cnt;
    logic         page_full;
    logic [3:0]   gap;
    logic         overspeed;
    logic [3:0]   lane_o;
    logic [3:0]   oe_n;
    sfpi_ctrl_t   ctrl;
    logic [7:0]   tx_byte;
    logic [ADDR_W-1:0] er_addr;
    sfpi_erase_t  er_kind;
    logic         ack;
    logic [31:0]  rdata;
    logic         standby;
    logic         boost;
  } sfpi_core_t;
  sfpi_core_t st_r, st_nxt;

  logic [6:0] pin_s;
  logic       cs_n_s;
  logic       sclk_s;
  logic [3:0] lane_s;
  logic       boost_s;
  logic       paused;
  logic       hw_protect;
  logic       sr_blocked;

  // ==========================================================
  // helpers
  function automatic logic [3:0] lane_bits(input sfpi_width_t w);
    case (w)
      W_DUAL:  lane_bits = 4'h2;
      W_QUAD:  lane_bits = 4'h4;
      default: lane_bits = 4'h1;
    endcase
  endfunction

  // quad falls back to single while quad_enable_bit is clear
  function automatic sfpi_width_t lane_width(input sfpi_ctrl_t c);
    lane_width = W_SINGLE;
    if (c.four_wire_command_mode) begin
      lane_width = W_QUAD;
    end else if (c.width == W_DUAL) begin
      lane_width = W_DUAL;
    end else if (c.width == W_QUAD && c.quad_enable_bit) begin
      lane_width = W_QUAD;                        // RULE8
    end
  endfunction

  // top bits of the out shifter onto the active lanes
  function automatic logic [3:0] out_lanes(input logic [7:0] s, input sfpi_width_t w);
    case (w)
      W_DUAL:  out_lanes = {2'h0, s[7:6]};        // RULE7
      W_QUAD:  out_lanes = s[7:4];                // RULE7
      default: out_lanes = {2'h0, s[7], 1'b0};    // RULE6
    endcase
  endfunction

  function automatic logic [ADDR_W-1:0] erase_base(
    input logic [ADDR_W-1:0] a, input sfpi_erase_t k);
    logic [ADDR_W-1:0] m;
    m = '0;
    case (k)
      ER_SECTOR: m = ADDR_W'(SECTOR_BYTES - 1);
      ER_BLK32:  m = ADDR_W'(BLK32_BYTES - 1);
      ER_BLK64:  m = ADDR_W'(BLK64_BYTES - 1);
      default:   m = '1;
    endcase
    erase_base = a & ~m;                          // RULE16
  endfunction

  // ==========================================================
  // pin synchronisers
  sfpi_sync #(.W(7)) u_sync (
    .clk   (CLOCK),
    .rst_n (RST_N),
    .d     ({PROGRAM_BOOST_REQ, SELECT_N, SCLK, DATA_LANE_I}),
    .q     (pin_s)
  );
  assign boost_s = pin_s[6];
  assign cs_n_s = pin_s[5];
  assign sclk_s = pin_s[4];
  assign lane_s = pin_s[3:0];

  // pause pin is lane three unless quad mode owns it
  sfpi_hold u_hold (
    .clk    (CLOCK),
    .rst_n  (RST_N),
    .cs_n   (cs_n_s),
    .sclk   (sclk_s),
    .hold_n (lane_s[3]),
    .enable (!st_r.ctrl.quad_enable_bit),         // RULE13
    .paused (paused)
  );

  // ==========================================================
  // effective lane width; quad falls back to single without enable
  sfpi_width_t eff_w;
  logic        rise;
  logic        fall;
  logic        cs_fall;
  logic        go;
  assign eff_w = lane_width(st_r.ctrl);
  // protect pin is lane two unless quad mode owns it
  assign hw_protect = !st_r.ctrl.quad_enable_bit && !lane_s[2];               // RULE9 RULE10
  assign sr_blocked = hw_protect && (st_r.ctrl.status_lock_bits != 2'h0);     // RULE9
  assign rise    = sclk_s && !st_r.sclk_d;
  assign fall    = !sclk_s && st_r.sclk_d;
  assign cs_fall = !cs_n_s && st_r.cs_d;
  assign go      = st_r.state == ST_ACTIVE;

  // ==========================================================
  // main next-state process: link, then registers
  logic [3:0]  nb;
  logic [7:0]  din;
  logic [3:0]  mask;
  logic        bus_req;
  sfpi_ctrl_t  wc;
  logic        byte_done;
  always_comb begin
    nb      = lane_bits(eff_w);
    byte_done = 1'b0;
    din     = '0;
    mask    = '0;
    bus_req = WB_CYC_I && WB_STB_I;
    wc      = sfpi_ctrl_t'(WB_DAT_I[11:0]);
    st_nxt  = st_r;
    st_nxt.sclk_d = sclk_s;
    st_nxt.cs_d   = cs_n_s;
    // edge spacing watch for an overfast link
    if (rise || fall) begin
      st_nxt.gap = '0;
      if (st_r.gap < EDGE_GAP_MIN && !cs_n_s) begin
        st_nxt.overspeed = 1'b1;                  // RULE17
      end
    end else if (st_r.gap != 4'hf) begin
      st_nxt.gap = st_r.gap + 4'h1;
    end
    // select and pause states
    case (st_r.state)
      ST_IDLE: begin
        if (cs_fall) begin
          st_nxt.state     = ST_ACTIVE;           // RULE3
          st_nxt.armed     = 1'b1;                // RULE4
          st_nxt.idle_high = sclk_s;              // RULE18
          st_nxt.in_cnt    = '0;
          st_nxt.out_cnt   = nb;
          st_nxt.page_cnt  = '0;
          st_nxt.page_full = 1'b0;
          // mode 0 host samples before any fall: first bits go out now
          st_nxt.sh_out    = st_r.tx_byte << nb;
          st_nxt.lane_o    = out_lanes(st_r.tx_byte, eff_w);   // RULE6
        end
      end
      ST_ACTIVE: begin
        if (cs_n_s) begin
          st_nxt.state = ST_IDLE;                 // RULE1
        end else if (paused) begin
          st_nxt.state = ST_PAUSE;                // RULE11
        end
      end
      ST_PAUSE: begin
        if (cs_n_s) begin
          st_nxt.state  = ST_IDLE;                // RULE20
          st_nxt.in_cnt = '0;
        end else if (!paused) begin
          st_nxt.state = ST_ACTIVE;               // RULE12
        end
      end
      default: st_nxt.state = ST_IDLE;
    endcase
    // inbound bits on rising link edges
    if (go && st_r.armed && rise) begin
      case (eff_w)
        W_DUAL:  din = {st_r.sh_in[5:0], lane_s[1:0]};       // RULE7
        W_QUAD:  din = {st_r.sh_in[3:0], lane_s};            // RULE7
        default: din = {st_r.sh_in[6:0], lane_s[0]};         // RULE5
      endcase
      st_nxt.sh_in = din;
      if (st_r.in_cnt + nb >= 4'h8) begin
        st_nxt.in_cnt   = '0;
        st_nxt.rx_byte  = din;
        st_nxt.rx_valid = 1'b1;
        byte_done       = 1'b1;
        if (st_r.page_cnt == 9'(PAGE_BYTES)) begin
          st_nxt.page_full = 1'b1;                // RULE15
        end else begin
          st_nxt.page_cnt = st_r.page_cnt + 9'h1;
        end
      end else begin
        st_nxt.in_cnt = st_r.in_cnt + nb;
      end
    end
    // outbound bits change on falling link edges
    if (go && st_r.armed && fall && st_r.ctrl.drive_out) begin
      st_nxt.lane_o = out_lanes(st_r.sh_out, eff_w);         // RULE6 RULE7
      if (st_r.out_cnt + nb >= 4'h8) begin
        st_nxt.out_cnt = '0;
        st_nxt.sh_out  = st_r.tx_byte;
      end else begin
        st_nxt.out_cnt = st_r.out_cnt + nb;
        st_nxt.sh_out  = st_r.sh_out << nb;
      end
    end
    // lane drivers: only while selected, not paused, driving
    if (st_nxt.state == ST_ACTIVE && st_r.ctrl.drive_out) begin
      case (eff_w)
        W_DUAL:  mask = 4'h3;
        W_QUAD:  mask = 4'hf;
        default: mask = 4'h2;
      endcase
    end
    st_nxt.oe_n = ~mask;                          // RULE1 RULE11
    // wishbone: answer one cycle after the request edge
    st_nxt.ack = bus_req && !st_r.ack;
    if (bus_req && !st_r.ack) begin
      case (WB_ADR_I)
        CTRL_ADDR:  st_nxt.rdata = {20'h0, st_r.ctrl};
        STAT_ADDR:  st_nxt.rdata = {7'h0, st_r.page_cnt, 6'h0,
                                    st_r.idle_high, st_r.overspeed,
                                    st_r.page_full, BOOST_EN,
                                    hw_protect, sr_blocked, st_r.armed,
                                    paused, STANDBY, !cs_n_s};
        TXD_ADDR:   st_nxt.rdata = {24'h0, st_r.tx_byte};
        RXD_ADDR:   st_nxt.rdata = {23'h0, st_r.rx_valid, st_r.rx_byte};
        ERASE_ADDR: st_nxt.rdata = {6'h0, st_r.er_kind, 1'b0,
                                    erase_base(st_r.er_addr, st_r.er_kind)};
        default:    st_nxt.rdata = '0;
      endcase
    end
    // side effects at the edge where ack is seen
    if (bus_req && st_r.ack) begin
      // a byte landing in the same cycle wins over the read clear
      if (!WB_WE_I && WB_ADR_I == RXD_ADDR && !byte_done) begin
        st_nxt.rx_valid = 1'b0;
      end
      if (WB_WE_I && WB_ADR_I == CTRL_ADDR && WB_SEL_I[0]) begin
        if (!sr_blocked) begin
          st_nxt.ctrl = wc;                       // RULE9
          st_nxt.ctrl.four_wire_command_mode =
            wc.four_wire_command_mode && wc.quad_enable_bit;  // RULE8
        end else begin
          st_nxt.ctrl.drive_out = wc.drive_out;
          st_nxt.ctrl.width     = wc.width;
          st_nxt.ctrl.busy      = wc.busy;
        end
      end
      if (WB_WE_I && WB_ADR_I == TXD_ADDR && WB_SEL_I[0]) begin
        st_nxt.tx_byte = WB_DAT_I[7:0];
      end
      if (WB_WE_I && WB_ADR_I == ERASE_ADDR && WB_SEL_I == 4'hf) begin
        st_nxt.er_addr = WB_DAT_I[ADDR_W-1:0];
        st_nxt.er_kind = sfpi_erase_t'(WB_DAT_I[25:24]);
      end
    end
    // power and boost follow the settled next state
    st_nxt.standby = st_nxt.state == ST_IDLE && !st_nxt.ctrl.busy;          // RULE2
    st_nxt.boost   = boost_s && lane_width(st_nxt.ctrl) == W_SINGLE;        // RULE14
  end

  // ==========================================================
  // state register; reset leaves the link deselected in SPI mode
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      st_r         <= '0;
      st_r.state   <= ST_IDLE;
      st_r.sclk_d  <= 1'b1;
      st_r.cs_d    <= 1'b1;
      st_r.oe_n    <= 4'hf;
      st_r.standby <= 1'b1;
      st_r.ctrl    <= sfpi_ctrl_t'(CTRL_RST[11:0]);  // RULE21
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flops
  assign WB_DAT_O       = st_r.rdata;
  assign WB_ACK_O       = st_r.ack;
  assign DATA_LANE_O    = st_r.lane_o;
  assign DATA_LANE_OE_N = st_r.oe_n;
  assign STANDBY        = st_r.standby;
  assign BOOST_EN       = st_r.boost;

  // ==========================================================
  // checks
  sequence s_bus_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_ack_pulse;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence
  bus_ack_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    s_bus_req |=> s_ack_pulse) else $error("bus answer not a single pulse");
  deselect_hiz_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE1
    st_r.state == ST_IDLE |-> DATA_LANE_OE_N == 4'hf) else $error("lane driven deselected");
  pause_hiz_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE11
    st_r.state == ST_PAUSE |-> DATA_LANE_OE_N == 4'hf) else $error("lane driven in pause");
  standby_on_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE2
    (cs_n_s && !st_r.ctrl.busy && !bus_req) |=> STANDBY) else $error("no standby");
  boost_lane_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE14
    BOOST_EN |-> eff_w == W_SINGLE) else $error("boost outside single lane");
  quad_lane_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE8
    eff_w == W_QUAD |-> st_r.ctrl.quad_enable_bit) else $error("quad without enable");
  hold_off_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE13
    st_r.ctrl.quad_enable_bit |=> !paused) else $error("pause with quad enabled");
  page_cap_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // RULE15
    st_r.page_cnt <= 9'(PAGE_BYTES)) else $error("page count past one page");
endmodule
`default_nettype wire

// >>> bench/sfpi_host_model.sv
// host-side model of the serial link: select, link clock and lanes
// assumes the bench resolves each lane wire from both parties' enables
`timescale 1ns/10ps
`default_nettype none
module sfpi_host_model (
  // link pins driven by the host
  output logic       sel_n,
  output logic       sclk,
  output logic [3:0] drv,
  output logic [3:0] en,
  // resolved lane wires
  input  wire logic [3:0] lane
);
  // ==========================================================
  // shift registers, loaded and read by the bench
  logic [7:0] txr;
  logic [7:0] rxr;
  // lane1 released so the device alone drives it; protect and pause held high
  initial begin
    sel_n = 1'b1;
    sclk  = 1'b0;
    drv   = 4'hc;
    en    = 4'hd;
    txr   = 8'h00;
    rxr   = 8'h00;
  end
  // select edges only while the clock idles low, mode 0
  task automatic sel(input logic v);
    #62.5 sel_n = v;
    #62.5;
  endtask
  // 125 ns link period stays below the fastest allowed rate
  task automatic bits(input int n);
    for (int i = 0; i < n; i++) begin
      drv[0] = txr[7];
      txr    = {txr[6:0], 1'b0};
      #62.5 sclk = 1'b1;
      rxr    = {rxr[6:0], lane[1]};
      #62.5 sclk = 1'b0;
    end
  endtask
  // pause pin moves only while the clock is low
  task automatic hold(input logic v);
    #62.5 drv[3] = v;
    #62.5;
  endtask
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench: wishbone master, host link model, read monitor
// assumes the front end answers each wishbone cycle within 100 clocks
`timescale 1ns/10ps
`default_nettype none
module testbench
  import sfpi_pkg::*;
;
  // ==========================================================
  // signals
  logic        clock;
  logic        rst_n;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_we;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack;
  logic        sel_n;
  logic        sclk;
  logic [3:0]  lane_i;
  logic [3:0]  lane_o;
  logic [3:0]  lane_oe_n;
  logic [3:0]  host_drv;
  logic [3:0]  host_en;
  logic [3:0]  last_lvl;
  logic        boost_req;
  logic        standby;
  logic        boost_en;
  logic [31:0] exp_q[$];
  int          mismatches;
  int          n_checks;
  int          cycles;
  // ==========================================================
  sfpi_core i_dut (
    .CLOCK(clock), .RST_N(rst_n), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb),
    .WB_WE_I(wb_we), .WB_ADR_I(wb_adr), .WB_SEL_I(wb_sel), .WB_DAT_I(wb_dat_i),
    .WB_DAT_O(wb_dat_o), .WB_ACK_O(wb_ack), .SELECT_N(sel_n), .SCLK(sclk),
    .DATA_LANE_I(lane_i), .DATA_LANE_O(lane_o), .DATA_LANE_OE_N(lane_oe_n),
    .PROGRAM_BOOST_REQ(boost_req), .STANDBY(standby), .BOOST_EN(boost_en)
  );
  sfpi_host_model i_host (
    .sel_n(sel_n), .sclk(sclk), .drv(host_drv), .en(host_en), .lane(lane_i)
  );
  // undriven lanes show the inverse of their last level, never a stale value
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lane_i[i] = !lane_oe_n[i] ? lane_o[i] : host_en[i] ? host_drv[i] : ~last_lvl[i];
    end
  end
  always @(posedge clock) last_lvl <= lane_i;
  // ==========================================================
  // clock, timeout, verdict, comparison
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // a hang ends here long after the sequence should be done
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // read data is taken at the edge that samples ack
  always @(posedge clock) begin
    if (wb_ack === 1'b1 && wb_cyc && !wb_we) begin
      if (exp_q.size() == 0) check(wb_dat_o, 32'hffff_ffff);
      else check(wb_dat_o, exp_q.pop_front());
    end
  end
  // ==========================================================
  // classic wishbone single cycle, held until ack
  task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [31:0] d,
                          input logic [3:0] s);
    int n;
    n = 0;
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= a;
    wb_sel   <= s;
    wb_dat_i <= d;
    @(posedge clock);
    while (wb_ack !== 1'b1 && n < 100) begin
      @(posedge clock);
      n++;
    end
    if (n == 100) mismatches++;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wb_read(input logic [7:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    wb_cycle(1'b0, a, 32'h0, 4'hf);
  endtask
  task automatic settle();
    repeat (10) @(posedge clock);
  endtask
  // ==========================================================
  initial begin : main
    sfpi_ctrl_t c;
    sfpi_ctrl_t c2;
    logic [7:0] b;
    logic [ADDR_W-1:0] a;
    logic [ADDR_W-1:0] m;
    rst_n = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_dat_i = 32'h0;
    boost_req = 1'b0;
    last_lvl = 4'h0;
    mismatches = 0;
    n_checks = 0;
    cycles = 0;
    void'($urandom(15));
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    settle();
    // reset state, unmapped address, idle pins
    wb_read(CTRL_ADDR, CTRL_RST);
    wb_read(8'h14, 32'h0);
    wb_read(8'he0 | 8'($urandom), 32'h0);
    check({28'h0, lane_oe_n}, 32'hf);
    check({31'h0, standby}, 32'h1);
    // inbound byte on the serial input
    b = 8'($urandom);
    i_host.sel(1'b0);
    settle();
    check({31'h0, standby}, 32'h0);
    i_host.txr = b;
    i_host.bits(8);
    i_host.sel(1'b1);
    settle();
    wb_read(RXD_ADDR, {23'h0, 1'b1, b});
    // outbound byte, paused in mid-byte and resumed
    b = 8'($urandom);
    wb_cycle(1'b1, TXD_ADDR, {24'h0, b}, 4'hf);
    // a write without lane zero of the byte select is dropped
    wb_cycle(1'b1, TXD_ADDR, {24'($urandom), ~b}, 4'he);
    wb_read(TXD_ADDR, {24'h0, b});
    c = '0;
    c.drive_out = 1'b1;
    wb_cycle(1'b1, CTRL_ADDR, {20'h0, c}, 4'hf);
    i_host.sel(1'b0);
    i_host.bits(4);
    i_host.hold(1'b0);
    settle();
    check({31'h0, lane_oe_n[1]}, 32'h1);
    i_host.hold(1'b1);
    settle();
    i_host.bits(4);
    check({24'h0, i_host.rxr}, {24'h0, b});
    i_host.sel(1'b1);
    settle();
    check({28'h0, lane_oe_n}, 32'hf);
    // boost honoured in single lane only, every width
    boost_req <= 1'b1;
    for (int w = 0; w < 3; w++) begin
      c = '0;
      c.width = sfpi_width_t'(w);
      c.quad_enable_bit = (w == 2);
      wb_cycle(1'b1, CTRL_ADDR, {20'h0, c}, 4'hf);
      settle();
      check({31'h0, boost_en}, {31'h0, w == 0});
    end
    boost_req <= 1'b0;
    // with quad enabled the pause pin is a lane and pauses nothing
    c = '0;
    c.quad_enable_bit = 1'b1;
    c.drive_out = 1'b1;
    wb_cycle(1'b1, CTRL_ADDR, {20'h0, c}, 4'hf);
    i_host.sel(1'b0);
    i_host.hold(1'b0);
    settle();
    check({31'h0, lane_oe_n[1]}, 32'h0);
    i_host.hold(1'b1);
    i_host.sel(1'b1);
    settle();
    // protect pin low with lock bits: only live fields move
    c = '0;
    c.status_lock_bits = 2'h1;
    wb_cycle(1'b1, CTRL_ADDR, {20'h0, c}, 4'hf);
    i_host.drv[2] = 1'b0;
    settle();
    c2 = '0;
    c2.block_protect = 3'h5;
    c2.busy = 1'b1;
    c2.width = W_DUAL;
    wb_cycle(1'b1, CTRL_ADDR, {20'h0, c2}, 4'hf);
    settle();
    check({31'h0, standby}, 32'h0);
    c.busy = 1'b1;
    c.width = W_DUAL;
    wb_read(CTRL_ADDR, {20'h0, c});
    // with quad enabled the pin is a lane and protects nothing
    i_host.drv[2] = 1'b1;
    settle();
    c = '0;
    c.status_lock_bits = 2'h1;
    c.quad_enable_bit = 1'b1;
    wb_cycle(1'b1, CTRL_ADDR, {20'h0, c}, 4'hf);
    i_host.drv[2] = 1'b0;
    settle();
    c.block_protect = 3'h5;
    wb_cycle(1'b1, CTRL_ADDR, {20'h0, c}, 4'hf);
    wb_read(CTRL_ADDR, {20'h0, c});
    wb_cycle(1'b1, CTRL_ADDR, 32'h0, 4'hf);
    i_host.drv[2] = 1'b1;
    // erase base rounds down to the chosen granule; spare bits read zero
    for (int k = 0; k < 4; k++) begin
      a = ADDR_W'($urandom);
      case (k)
        0: m = ADDR_W'(SECTOR_BYTES - 1);
        1: m = ADDR_W'(BLK32_BYTES - 1);
        2: m = ADDR_W'(BLK64_BYTES - 1);
        default: m = '1;
      endcase
      wb_cycle(1'b1, ERASE_ADDR, {6'($urandom), 2'(k), 1'b1, a}, 4'hf);
      wb_read(ERASE_ADDR, {6'h0, 2'(k), 1'b0, a & ~m});
    end
    settle();
    give_verdict();
  end
endmodule
`default_nettype wire
